// *** hw/repeater_pkg.sv ***
/*
  Constants and carrier types for the fibre bus repeater controller.
  Assumes a single 200 MHz clock and an APB register port.
*/
// Functional notes
// - Idle timeout 5, 10, 20 s or 65535 bits
// - Without extension, fault limit one to eight
// - With extension, limit 31/63/127/255, default 31
// - Qualify switch: alarm only on local faults
// - Line end ignores missing second channel
// - Focal point breaks ring as line end
// - Electrical data retimed, sent on channel one
// - Channel two data to electrical and channel one
// - Responses forwarded in reverse direction
// - Focal point sends both channels on fault
// - All links up: link lamps on, local fault off
// - Multidrop fault stops traffic beyond it
// - Bus active when rate known and frames arrive
// - Rate found from start delimiters, restarts
// - Default alarm on local and remote faults
// - Focal point flashes power indicator
package repeater_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned IDLE_SEC_0 = 5;
  localparam int unsigned IDLE_SEC_1 = 10;
  localparam int unsigned IDLE_SEC_2 = 20;
  localparam int unsigned IDLE_BITS = 65535;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned ACT_CYC = CLK_HZ / 1000 * 50;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned EXT_LIMIT_0 = 31;
  localparam int unsigned EXT_LIMIT_1 = 63;
  localparam int unsigned EXT_LIMIT_2 = 127;
  localparam int unsigned EXT_LIMIT_3 = 255;
  localparam logic [7:0] SD1 = 8'h10;
  localparam logic [7:0] SD2 = 8'h68;
  localparam logic [7:0] SD3 = 8'hA2;
  localparam logic [7:0] SD4 = 8'hDC;
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RATE = 12'h008;
  localparam logic [11:0] ADDR_FAULTS = 12'h00C;
  localparam logic [11:0] ADDR_TX = 12'h010;
  localparam logic [11:0] ADDR_RX = 12'h014;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0002;
  localparam int unsigned CFG_QUALIFY = 0;
  localparam int unsigned CFG_EXTENDED = 1;
  localparam int unsigned CFG_LIMIT_LO = 2;
  localparam int unsigned CFG_LINE_END = 5;
  localparam int unsigned CFG_FOCAL = 6;
  localparam int unsigned CFG_IDLE_LO = 7;
  typedef enum logic [1:0] {IDLE_5S = 2'h0, IDLE_10S = 2'h1, IDLE_20S = 2'h2,
                            IDLE_BITS_SEL = 2'h3} idle_sel_e;
  typedef struct packed {
    idle_sel_e idle_sel;
    logic focal;
    logic line_end;
    logic [2:0] limit_sel;
    logic extended;
    logic qualify;
  } config_s;
  typedef struct packed {
    logic valid;
    logic [1:0] src;
    logic [7:0] data;
  } frame_byte_s;
  localparam logic [1:0] SRC_ELEC = 2'h0;
  localparam logic [1:0] SRC_CH1 = 2'h1;
  localparam logic [1:0] SRC_CH2 = 2'h2;
endpackage : repeater_pkg

// *** hw/byte_fifo.sv ***
/*
  Synchronous FIFO holding received bytes on their way to the outputs.
  Assumes one clock; read data come out of a register.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("byte_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire stored = (wr_reg != rd_reg);
  wire push = in_valid && in_ready;
  wire pop = stored && (!out_valid || out_ready);
  assign in_ready = !full;
  always_ff @(posedge pclk) begin
    if (push) mem[wr_reg[AW-1:0]] <= in_data;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
        out_data <= mem[rd_reg[AW-1:0]];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : byte_fifo

// *** hw/rate_supervisor.sv ***
/*
  Bit-rate supervision: idle timeout and faulty-frame limit.
  Assumes frame starts and bit ticks are one-cycle pulses in pclk's domain.
*/
`timescale 1ns/1ps
module rate_supervisor #(
  parameter int unsigned IDLE_BASE_CYC = repeater_pkg::CLK_HZ * repeater_pkg::IDLE_SEC_0
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings.
  input wire repeater_pkg::config_s cfg,
  // Events.
  input wire logic rate_lock,
  input wire logic frame_ok,
  input wire logic frame_bad,
  input wire logic bit_tick,
  // State.
  output logic identified,
  output logic [7:0] fault_count
);
  logic [33:0] idle_reg;
  logic [33:0] idle_limit;
  logic [7:0] limit;
  always_comb begin
    case (cfg.idle_sel)
      repeater_pkg::IDLE_5S: idle_limit = 34'(IDLE_BASE_CYC);
      repeater_pkg::IDLE_10S: idle_limit = 34'(IDLE_BASE_CYC) * 34'd2;
      repeater_pkg::IDLE_20S: idle_limit = 34'(IDLE_BASE_CYC) * 34'd4;
      default: idle_limit = 34'(repeater_pkg::IDLE_BITS);
    endcase
  end
  always_comb begin
    if (cfg.extended) begin
      case (cfg.limit_sel[1:0])
        2'h0: limit = 8'(repeater_pkg::EXT_LIMIT_0);
        2'h1: limit = 8'(repeater_pkg::EXT_LIMIT_1);
        2'h2: limit = 8'(repeater_pkg::EXT_LIMIT_2);
        default: limit = 8'(repeater_pkg::EXT_LIMIT_3);
      endcase
    end else begin
      limit = {5'h00, cfg.limit_sel} + 8'h01;
    end
  end
  wire idle_tick = (cfg.idle_sel == repeater_pkg::IDLE_BITS_SEL) ? bit_tick : 1'b1;
  wire timeout = identified && (idle_reg >= idle_limit - 34'd1) && idle_tick;
  wire too_many = identified && frame_bad && (fault_count + 8'h01 >= limit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      identified <= 1'b0;
      fault_count <= 8'h00;
      idle_reg <= '0;
    end else begin
      if (!identified || frame_ok || frame_bad) idle_reg <= '0;
      else if (idle_tick) idle_reg <= idle_reg + 34'd1;
      if (timeout || too_many) begin
        identified <= 1'b0;
        fault_count <= 8'h00;
      end else if (!identified) begin
        identified <= rate_lock;
        fault_count <= 8'h00;
      end else if (frame_ok) begin
        fault_count <= 8'h00;
      end else if (frame_bad) begin
        fault_count <= fault_count + 8'h01;
      end
    end
  end
endmodule : rate_supervisor

// *** hw/repeater_ctrl.sv ***
/*
  Top of the repeater controller: receives bytes from the electrical port
  and both fibre channels, forwards them by role, supervises the bit rate,
  drives indicators and the alarm relay, and offers APB registers.
  Assumes byte receivers in front of it; their strobes come from pins and
  are synchronised here, so a strobe must last at least three clocks.
*/
`timescale 1ns/1ps
module repeater_ctrl #(
  parameter int unsigned IDLE_BASE_CYC = repeater_pkg::CLK_HZ * repeater_pkg::IDLE_SEC_0,
  parameter int unsigned FLASH_CYC = repeater_pkg::FLASH_CYC,
  parameter int unsigned FIFO_DEPTH = repeater_pkg::FIFO_DEPTH
) (
  // APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received bytes and link state from pins.
  input wire logic elec_rx_stb,
  input wire logic fibre_one_rx_stb,
  input wire logic fibre_two_rx_stb,
  input wire logic [7:0] elec_rx_data,
  input wire logic [7:0] fibre_one_rx_data,
  input wire logic [7:0] fibre_two_rx_data,
  input wire logic fibre_one_link_in,
  input wire logic fibre_two_link_in,
  input wire logic remote_fault_in,
  input wire logic [15:0] bit_period_cyc,
  // Forwarded bytes.
  output logic elec_tx_valid,
  output logic fibre_one_tx_valid,
  output logic fibre_two_tx_valid,
  output logic [7:0] tx_data,
  // Indicators and relay.
  output logic fibre_channel_one,
  output logic fibre_channel_two,
  output logic local_link_fault_flag,
  output logic remote_link_fault_flag,
  output logic bus_active,
  output logic power_indicator,
  output logic electrical_rx_indicator,
  output logic optical_rx_indicator,
  output logic alarm_relay
);
  initial begin
    if (FIFO_DEPTH < 2) $error("repeater_ctrl fifo depth too small");
  end

  // Two-stage synchronisers; the first stage feeds only the second.
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [2:0] stb_prev_reg;
  wire [5:0] raw_in = {remote_fault_in, fibre_two_link_in, fibre_one_link_in,
                       fibre_two_rx_stb, fibre_one_rx_stb, elec_rx_stb};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      stb_prev_reg <= 3'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      stb_prev_reg <= sync2_reg[2:0];
    end
  end
  // Data buses are sampled when the synchronised strobe rises; they must be stable by then.
  wire [2:0] rx_rise = sync2_reg[2:0] & ~stb_prev_reg;
  wire link_one = sync2_reg[3];
  wire link_two = sync2_reg[4];
  wire remote_fault = sync2_reg[5];

  // Configuration register.
  repeater_pkg::config_s cfg_reg;
  logic [7:0] fifo_drops_reg;

  // Select one received byte per cycle; the electrical port has priority.
  repeater_pkg::frame_byte_s rx_sel;
  always_comb begin
    rx_sel = '0;
    if (rx_rise[0]) rx_sel = '{valid: 1'b1, src: repeater_pkg::SRC_ELEC, data: elec_rx_data};
    else if (rx_rise[2])
      rx_sel = '{valid: 1'b1, src: repeater_pkg::SRC_CH2, data: fibre_two_rx_data};
    else if (rx_rise[1])
      rx_sel = '{valid: 1'b1, src: repeater_pkg::SRC_CH1, data: fibre_one_rx_data};
  end

  // Rate detection by start delimiters on any interface.
  logic in_frame_reg;
  logic [15:0] gap_reg;
  logic [15:0] bit_reg;
  wire is_sd = (rx_sel.data == repeater_pkg::SD1) || (rx_sel.data == repeater_pkg::SD2) ||
               (rx_sel.data == repeater_pkg::SD3) || (rx_sel.data == repeater_pkg::SD4);
  wire frame_start = rx_sel.valid && !in_frame_reg;
  wire frame_ok = frame_start && is_sd;
  wire frame_bad = frame_start && !is_sd;
  wire bit_tick = (bit_reg == 16'h0000);
  logic identified;
  logic [7:0] fault_count;
  rate_supervisor #(.IDLE_BASE_CYC(IDLE_BASE_CYC)) u_sup (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_reg),
    .rate_lock(frame_ok),
    .frame_ok(frame_ok),
    .frame_bad(frame_bad),
    .bit_tick(bit_tick),
    .identified(identified),
    .fault_count(fault_count)
  );
  // A frame ends after eleven idle bit periods (one character time).
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_reg <= 1'b0;
      gap_reg <= 16'h0000;
      bit_reg <= 16'h0000;
    end else begin
      bit_reg <= bit_tick ? bit_period_cyc : bit_reg - 16'h0001;
      if (rx_sel.valid) begin
        in_frame_reg <= 1'b1;
        gap_reg <= 16'h0000;
      end else if (bit_tick && in_frame_reg) begin
        gap_reg <= gap_reg + 16'h0001;
        if (gap_reg >= 16'd10) in_frame_reg <= 1'b0;
      end
    end
  end

  // Received bytes queue in the FIFO; a full FIFO drops and counts.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [9:0] fifo_out_data;
  wire [1:0] out_src = fifo_out_data[9:8];
  byte_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_sel.valid && identified),
    .in_ready(fifo_in_ready),
    .in_data({rx_sel.src, rx_sel.data}),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  // Link faults and routing.
  wire two_needed = !cfg_reg.line_end;
  wire local_fault = !link_one || (two_needed && !link_two);
  wire ring_broken = cfg_reg.focal && (local_fault || remote_fault);
  logic to_elec;
  logic to_one;
  logic to_two;
  always_comb begin
    to_elec = 1'b0;
    to_one = 1'b0;
    to_two = 1'b0;
    case (out_src)
      repeater_pkg::SRC_ELEC: begin
        to_one = link_one;
        to_two = ring_broken && link_two;
      end
      repeater_pkg::SRC_CH2: begin
        to_elec = 1'b1;
        to_one = link_one && !cfg_reg.focal;
      end
      repeater_pkg::SRC_CH1: begin
        to_elec = 1'b1;
        to_two = link_two && (!cfg_reg.focal || ring_broken);
      end
      default: begin
        to_elec = 1'b0;
      end
    endcase
  end

  // Indicator timers.
  logic [31:0] flash_reg;
  logic flash_phase_reg;
  logic [31:0] elec_act_reg;
  logic [31:0] opt_act_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reg <= 32'h0000_0000;
      flash_phase_reg <= 1'b1;
      elec_act_reg <= 32'h0000_0000;
      opt_act_reg <= 32'h0000_0000;
    end else begin
      // Parked in the lit phase while not focal, so the first dark phase is never cut short.
      if (!cfg_reg.focal) begin
        flash_reg <= 32'h0000_0000;
        flash_phase_reg <= 1'b1;
      end else if (flash_reg >= FLASH_CYC - 1) begin
        flash_reg <= 32'h0000_0000;
        flash_phase_reg <= !flash_phase_reg;
      end else begin
        flash_reg <= flash_reg + 32'h0000_0001;
      end
      if (rx_rise[0]) elec_act_reg <= 32'(repeater_pkg::ACT_CYC);
      else if (elec_act_reg != 32'h0000_0000) elec_act_reg <= elec_act_reg - 32'h0000_0001;
      if (rx_rise[1] || rx_rise[2]) opt_act_reg <= 32'(repeater_pkg::ACT_CYC);
      else if (opt_act_reg != 32'h0000_0000) opt_act_reg <= opt_act_reg - 32'h0000_0001;
    end
  end

  // Registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elec_tx_valid <= 1'b0;
      fibre_one_tx_valid <= 1'b0;
      fibre_two_tx_valid <= 1'b0;
      tx_data <= 8'h00;
      fibre_channel_one <= 1'b0;
      fibre_channel_two <= 1'b0;
      local_link_fault_flag <= 1'b0;
      remote_link_fault_flag <= 1'b0;
      bus_active <= 1'b0;
      power_indicator <= 1'b0;
      electrical_rx_indicator <= 1'b0;
      optical_rx_indicator <= 1'b0;
      alarm_relay <= 1'b0;
    end else begin
      elec_tx_valid <= fifo_out_valid && to_elec;
      fibre_one_tx_valid <= fifo_out_valid && to_one;
      fibre_two_tx_valid <= fifo_out_valid && to_two;
      tx_data <= fifo_out_data[7:0];
      fibre_channel_one <= link_one;
      fibre_channel_two <= link_two;
      local_link_fault_flag <= local_fault;
      remote_link_fault_flag <= remote_fault;
      // Identification lapses after the idle time, so it also means frames keep arriving.
      bus_active <= identified;
      power_indicator <= cfg_reg.focal ? flash_phase_reg : 1'b1;
      electrical_rx_indicator <= elec_act_reg != 32'h0000_0000;
      optical_rx_indicator <= opt_act_reg != 32'h0000_0000;
      alarm_relay <= local_fault || (!cfg_reg.qualify && remote_fault);
    end
  end

  // APB slave: zero wait states, unmapped reads return zero with an error.
  wire access = psel && penable;
  wire hit_cfg = paddr == repeater_pkg::ADDR_CONFIG;
  wire hit_status = paddr == repeater_pkg::ADDR_STATUS;
  wire hit_rate = paddr == repeater_pkg::ADDR_RATE;
  wire hit_faults = paddr == repeater_pkg::ADDR_FAULTS;
  wire mapped = hit_cfg || hit_status || hit_rate || hit_faults;
  wire [31:0] status_word = {23'h000000, alarm_relay, bus_active, identified,
                             remote_fault, local_fault, link_two, link_one, ring_broken};
  wire [31:0] read_word = hit_cfg ? {23'h000000, cfg_reg} :
                          hit_status ? status_word :
                          hit_rate ? {16'h0000, bit_period_cyc} :
                          hit_faults ? {16'h0000, fifo_drops_reg, fault_count} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= repeater_pkg::config_s'(repeater_pkg::CONFIG_RESET[8:0]);
      fifo_drops_reg <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) prdata <= read_word;
      if (access && pwrite && hit_cfg && pready) cfg_reg <= repeater_pkg::config_s'(pwdata[8:0]);
      if (rx_sel.valid && identified && !fifo_in_ready && fifo_drops_reg != 8'hFF)
        fifo_drops_reg <= fifo_drops_reg + 8'h01;
    end
  end
endmodule : repeater_ctrl

// *** tb/repeater_assertions.sv ***
/*
  Concurrent checks on the repeater controller's top-level ports.
  Assumes it is bound to repeater_ctrl with FLASH_CYC set to 8.
*/
`timescale 1ns/1ps
module repeater_assertions (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link side.
  input wire logic fibre_one_link_in,
  input wire logic fibre_two_link_in,
  input wire logic remote_fault_in,
  input wire logic fibre_one_tx_valid,
  // Indicators.
  input wire logic fibre_channel_one,
  input wire logic fibre_channel_two,
  input wire logic local_link_fault_flag,
  input wire logic remote_link_fault_flag,
  input wire logic power_indicator,
  input wire logic alarm_relay
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  links_up_a: assert property ((fibre_one_link_in && fibre_two_link_in) [*6] |->
    fibre_channel_one && fibre_channel_two && !local_link_fault_flag)
    else $error("links up but lamps wrong");
  remote_clear_a: assert property (!remote_fault_in [*6] |-> !remote_link_fault_flag)
    else $error("remote flag without cause");
  alarm_local_a: assert property (local_link_fault_flag [*2] |-> alarm_relay)
    else $error("local fault without alarm");
  alarm_quiet_a: assert property
    ((!local_link_fault_flag && !remote_link_fault_flag) [*2] |-> !alarm_relay)
    else $error("alarm without fault");
  gated_tx_a: assert property (fibre_one_tx_valid |-> fibre_channel_one)
    else $error("sent on dead channel");
  flash_hold_a: assert property ($fell(power_indicator) |=> !power_indicator [*7])
    else $error("flash period short");
endmodule : repeater_assertions

// *** tb/far_side.sv ***
/*
  Far-side model: byte receivers in front of the controller's strobes.
  Assumes the bench calls send; every byte is followed by a long gap.
*/
`timescale 1ns/1ps
module far_side (
  // Clock.
  input wire logic pclk,
  // Strobes and bytes, index 0 electrical, 1 channel one, 2 channel two.
  output logic [2:0] stb,
  output logic [23:0] data
);
  initial begin
    stb = 3'h0;
    data = 24'h0;
  end
  // The gap after each byte exceeds eleven bit times, so each byte opens a frame.
  task automatic send(input int s, input logic [7:0] d);
    @(posedge pclk);
    data[8*s +: 8] <= d;
    stb[s] <= 1'b1;
    repeat (4) @(posedge pclk);
    stb[s] <= 1'b0;
    data[8*s +: 8] <= ~d;
    repeat (64) @(posedge pclk);
  endtask : send
endmodule : far_side

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the repeater controller: APB master, far side, checks.
  Assumes the idle base is shortened to 1000 cycles and the flash period to 8.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int IDLE_N = 1000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, wv;
  logic pready, pslverr, err, p, ex;
  logic l1 = 1'b1, l2 = 1'b1, rem = 1'b0;
  logic [2:0] stb;
  logic [23:0] fd;
  logic ev, ov, tv, c1, c2, lf, rf, ba, pw, eri, ori, al;
  logic [7:0] txd, last_tx;
  int bad_count = 0, num_checks = 0, n_e = 0, n_o = 0, n_t = 0, sel, lim, seed;
  always #2.5 pclk = ~pclk;
  far_side i_far (.pclk(pclk), .stb(stb), .data(fd));
  repeater_ctrl #(.IDLE_BASE_CYC(IDLE_N), .FLASH_CYC(8), .FIFO_DEPTH(32)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .elec_rx_stb(stb[0]), .fibre_one_rx_stb(stb[1]), .fibre_two_rx_stb(stb[2]),
    .elec_rx_data(fd[7:0]), .fibre_one_rx_data(fd[15:8]), .fibre_two_rx_data(fd[23:16]),
    .fibre_one_link_in(l1), .fibre_two_link_in(l2), .remote_fault_in(rem),
    .bit_period_cyc(16'h0004), .elec_tx_valid(ev), .fibre_one_tx_valid(ov),
    .fibre_two_tx_valid(tv), .tx_data(txd), .fibre_channel_one(c1), .fibre_channel_two(c2),
    .local_link_fault_flag(lf), .remote_link_fault_flag(rf), .bus_active(ba),
    .power_indicator(pw), .electrical_rx_indicator(eri), .optical_rx_indicator(ori),
    .alarm_relay(al));
  always @(posedge pclk) begin
    n_e += int'(ev === 1'b1);
    n_o += int'(ov === 1'b1);
    n_t += int'(tv === 1'b1);
    if ((ev | ov | tv) === 1'b1) last_tx = txd;
  end
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // The master waits on pready without assuming a latency; the watchdog guards a hang.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string msg);
    apb(1'b0, a, 32'h0);
    chk(q & m, e, msg);
  endtask : rdchk
  task automatic cfg(input logic x, input int s, input logic le, input logic fo,
                     input logic qu, input int idle);
    apb(1'b1, repeater_pkg::ADDR_CONFIG,
        {23'h0, 2'(idle), fo, le, 3'(s), x, qu});
  endtask : cfg
  function automatic logic [7:0] sd(input int i);
    logic [7:0] t [4];
    t = '{repeater_pkg::SD1, repeater_pkg::SD2, repeater_pkg::SD3, repeater_pkg::SD4};
    return t[i & 3];
  endfunction : sd
  function automatic logic [7:0] bad_byte();
    logic [7:0] b;
    b = 8'($urandom);
    if (b == sd(0) || b == sd(1) || b == sd(2) || b == sd(3)) b = 8'h55;
    return b;
  endfunction : bad_byte
  task automatic fwd(input int s, input int xe, input int xo, input int xt);
    int e0, o0, t0;
    logic [7:0] d;
    d = sd($urandom);
    e0 = n_e;
    o0 = n_o;
    t0 = n_t;
    i_far.send(s, d);
    chk(n_e - e0, xe, "electrical output count");
    chk(n_o - o0, xo, "channel one output count");
    chk(n_t - t0, xt, "channel two output count");
    if (xe + xo + xt > 0) chk(last_tx, d, "forwarded byte");
  endtask : fwd
  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask : settle
  initial begin
    #400us;
    bad_count++;
    results();
  end
  initial begin
    seed = $urandom(24950);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(repeater_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, repeater_pkg::CONFIG_RESET, "reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    wv = $urandom & 32'hFFFF_FFBF;
    apb(1'b1, repeater_pkg::ADDR_CONFIG, wv);
    rdchk(repeater_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, wv & 32'h1FF, "config readback");
    rdchk(repeater_pkg::ADDR_RATE, 32'hFFFF, 32'h4, "rate register");
    rdchk(repeater_pkg::ADDR_STATUS, 32'h1E, 32'h06, "links up status");
    for (int i = 0; i < 12; i++) begin
      ex = (i >= 8);
      sel = ex ? i - 8 : i;
      lim = ex ? (32 << sel) - 1 : sel + 1;
      cfg(ex, sel, 1'b0, 1'b0, 1'b0, 2);
      i_far.send($urandom % 3, sd($urandom));
      for (int k = 1; k < lim; k++) i_far.send($urandom % 3, bad_byte());
      rdchk(repeater_pkg::ADDR_STATUS, 32'h20, 32'h20, "still identified");
      rdchk(repeater_pkg::ADDR_FAULTS, 32'hFF, lim - 1, "fault count");
      i_far.send($urandom % 3, bad_byte());
      rdchk(repeater_pkg::ADDR_STATUS, 32'h20, 32'h0, "rate dropped");
      rdchk(repeater_pkg::ADDR_FAULTS, 32'hFF, 32'h0, "count cleared");
    end
    for (int s = 0; s < 3; s++) begin
      cfg(1'b1, 0, 1'b0, 1'b0, 1'b0, s);
      i_far.send(0, sd(s));
      repeat ((IDLE_N << s) - 150) @(posedge pclk);
      rdchk(repeater_pkg::ADDR_STATUS, 32'h20, 32'h20, "idle too early");
      repeat (200) @(posedge pclk);
      rdchk(repeater_pkg::ADDR_STATUS, 32'h20, 32'h0, "idle timeout");
      chk(ba, 1'b0, "bus active when unidentified");
    end
    cfg(1'b1, 0, 1'b0, 1'b0, 1'b0, 2);
    i_far.send(1, sd(0));
    fwd(0, 0, 1, 0);
    chk(ba, 1'b1, "bus active");
    chk(eri, 1'b1, "electrical receive lamp");
    fwd(2, 1, 1, 0);
    chk(ori, 1'b1, "optical receive lamp");
    fwd(1, 1, 0, 1);
    l2 <= 1'b0;
    settle();
    chk(al, 1'b1, "alarm on local fault");
    cfg(1'b1, 0, 1'b1, 1'b0, 1'b0, 2);
    settle();
    chk(lf, 1'b0, "line end fault");
    l2 <= 1'b1;
    l1 <= 1'b0;
    cfg(1'b1, 0, 1'b0, 1'b0, 1'b0, 2);
    fwd(0, 0, 0, 0);
    l1 <= 1'b1;
    rem <= 1'b1;
    settle();
    chk({rf, al}, 2'h3, "remote alarm");
    cfg(1'b1, 0, 1'b0, 1'b0, 1'b1, 2);
    settle();
    chk(al, 1'b0, "qualified alarm");
    rem <= 1'b0;
    // Only this unit is focal; the bench stands for a ring with one focal point.
    cfg(1'b1, 0, 1'b0, 1'b1, 1'b0, 2);
    settle();
    fwd(0, 0, 1, 0);
    fwd(2, 1, 0, 0);
    p = pw;
    repeat (8) @(posedge pclk);
    chk(pw ^ p, 1'b1, "power flash");
    rem <= 1'b1;
    settle();
    rdchk(repeater_pkg::ADDR_STATUS, 32'h1, 32'h1, "ring broken");
    fwd(0, 0, 1, 1);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(repeater_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, repeater_pkg::CONFIG_RESET, "reset again");
    chk({eri, ori}, 2'h0, "receive lamps after reset");
    results();
  end
endmodule : tb_top
bind repeater_ctrl repeater_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fibre_one_link_in(fibre_one_link_in), .fibre_two_link_in(fibre_two_link_in),
  .remote_fault_in(remote_fault_in), .fibre_one_tx_valid(fibre_one_tx_valid),
  .fibre_channel_one(fibre_channel_one), .fibre_channel_two(fibre_channel_two),
  .local_link_fault_flag(local_link_fault_flag),
  .remote_link_fault_flag(remote_link_fault_flag),
  .power_indicator(power_indicator), .alarm_relay(alarm_relay));
